// *** hw/sfe_erase_ctrl.sv ***
// Serial flash erase, area lock and deep power-down command sequencer
`timescale 1ns/1ps
`include "sfe_regs.svh"

// Behaviour
// - Top sector unlock clears unfrozen subsector locks
// - Locked area rejects modifying commands
// - Lock write applies lock, then freeze
// - Page erase fills page with FFh
// - Erase needs write-arm latch set
// - Address bits A23-A19 ignored
// - Select must rise on exact byte boundary
// - Select rise starts cycle, flag while running
// - No page erase on protected page
// - No subsector erase in protected sector
// - No sector erase if hardware protected
// - Erase rejected while any cycle active
// - Array erase is opcode only, fills FFh
// - Array erase ignored if anything protected
// - Reset pin aborts cycle, enters reset
// - Idle deselect gives standby; sleep from standby
// - Sleep opcode alone, enters after delay
// - Sleep ignores write, program, erase
// - Power-on always lands in standby
// - Sleep rejected while cycle active
// - Only wake command or reset pin leaves sleep
// - Lock byte: freeze b1, lock b0
// - Reset pulse clears all lock bits
module sfe_erase_ctrl import sfe_pkg::*; #(
	parameter int PAGE_CLEAR_US = 10000, // page_clear_time
	parameter int SUBSECTOR_CLEAR_US = 50000, // subsector_clear_time
	parameter int SECTOR_CLEAR_US = 100000, // sector_clear_time
	parameter int ARRAY_CLEAR_US = 400000 // array_clear_time
) (
	input wire logic i_clock, // 250 MHz system clock
	input wire logic i_sys_rst, // Power-on reset, sync, high
	input wire logic i_sel_n, // Select pin, low active
	input wire logic i_sclk, // Serial clock pin
	input wire logic i_serial_in_line, // Serial data pin
	input wire logic i_hw_reset_n, // Hardware reset pin, low active
	input wire logic [7:0] i_hw_prot_sector, // Hardware protected sectors
	input wire logic i_ext_cycle_busy, // Program or write cycle running
	output logic o_cycle_active_flag, // Erase cycle running
	output logic o_write_arm_latch, // Write-arm latch
	output logic o_standby, // Standby power mode
	output logic o_deep_sleep, // Deep power-down mode
	output logic o_erase_go, // Pulse: array must fill region with FFh
	output logic [1:0] o_erase_kind, // Region size of erase
	output logic [18:0] o_erase_addr, // Any address in the region
	output logic o_erase_done, // Pulse: erase cycle finished
	output logic [7:0] o_area_write_lock, // Sector write locks
	output logic [7:0] o_area_freeze_bit, // Sector freeze bits
	output logic [15:0] o_sub_write_lock, // Top sector subsector locks
	output logic [15:0] o_sub_freeze_bit // Top sector subsector freezes
);
	// Cycle counts of each erase kind, at least one cycle
	localparam int PAGE_CYC = PAGE_CLEAR_US * 1000 / `SFE_CLK_PERIOD_NS;
	localparam int SUB_CYC = SUBSECTOR_CLEAR_US * 1000 / `SFE_CLK_PERIOD_NS;
	localparam int SEC_CYC = SECTOR_CLEAR_US * 1000 / `SFE_CLK_PERIOD_NS;
	localparam int ARRAY_CYC = ARRAY_CLEAR_US * 1000 / `SFE_CLK_PERIOD_NS;

	// Turns a cycle count into a counter preload
	function automatic logic [31:0] preload(input int cyc);
		preload = (cyc > 1) ? 32'(cyc - 1) : 32'h0000_0000;
	endfunction : preload

	// Sector index of an address
	function automatic logic [2:0] sector_of(input logic [18:0] addr);
		sector_of = addr[`SFE_SEC_HI:`SFE_SEC_LO];
	endfunction : sector_of

	// Pin synchronisers
	logic sel_meta_reg, sel_sync_reg, sel_prev_reg;
	logic clk_meta_reg, clk_sync_reg, clk_prev_reg;
	logic din_meta_reg, din_sync_reg;
	logic rst_meta_reg, rst_sync_reg;

	// Frame capture
	logic [39:0] shift_reg;
	logic [5:0] bit_cnt_reg;

	// Sequencer
	sfe_state_t state_reg;
	logic [31:0] cyc_cnt_reg;
	logic arm_reg;
	logic [7:0] sec_wl_reg, sec_ld_reg;
	logic [15:0] sub_wl_reg, sub_ld_reg;

	// Decode of the finished frame
	logic hw_rst, sel_rise, sel_fall, sclk_rise, busy;
	logic [7:0] op_8, op_32, op_40, lock_data;
	logic [18:0] addr_32, addr_40;
	logic [2:0] sec_32, sec_40;
	logic [3:0] sub_32, sub_40;
	logic area_locked, sub_locked, sec_locked, any_locked;
	logic do_arm, do_disarm, do_sleep, do_wake, do_lock_wr;
	logic do_page, do_sub, do_sec, do_array;

	// Two flops on every pin; only the second flop is read
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			sel_meta_reg <= 1'b1;
			sel_sync_reg <= 1'b1;
			clk_meta_reg <= 1'b0;
			clk_sync_reg <= 1'b0;
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= 1'b1;
		end else begin
			sel_meta_reg <= i_sel_n;
			sel_sync_reg <= sel_meta_reg;
			clk_meta_reg <= i_sclk;
			clk_sync_reg <= clk_meta_reg;
			din_meta_reg <= i_serial_in_line;
			din_sync_reg <= din_meta_reg;
			rst_meta_reg <= i_hw_reset_n;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Edge history for select and serial clock
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			sel_prev_reg <= 1'b1;
			clk_prev_reg <= 1'b0;
		end else begin
			sel_prev_reg <= sel_sync_reg;
			clk_prev_reg <= clk_sync_reg;
		end
	end

	assign hw_rst = ~rst_sync_reg;
	assign sel_rise = sel_sync_reg & ~sel_prev_reg;
	assign sel_fall = ~sel_sync_reg & sel_prev_reg;
	assign sclk_rise = clk_sync_reg & ~clk_prev_reg & ~sel_sync_reg;
	assign busy = (state_reg == SFE_ST_BUSY) | i_ext_cycle_busy;

	// Bits shift in on serial clock rise; count saturates so long frames fail
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || hw_rst) begin
			shift_reg <= 40'h00_0000_0000;
			bit_cnt_reg <= 6'h00;
		end else if (sel_fall) begin
			bit_cnt_reg <= 6'h00;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[38:0], din_sync_reg};
			if (bit_cnt_reg != `SFE_LEN_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			end
		end
	end

	// Field views for each legal frame length
	assign op_8 = shift_reg[7:0];
	assign op_32 = shift_reg[31:24];
	assign op_40 = shift_reg[39:32];
	assign addr_32 = shift_reg[18:0];
	assign addr_40 = shift_reg[26:8];
	assign lock_data = shift_reg[7:0];
	assign sec_32 = sector_of(addr_32);
	assign sec_40 = sector_of(addr_40);
	assign sub_32 = addr_32[`SFE_SUB_HI:`SFE_SUB_LO];
	assign sub_40 = addr_40[`SFE_SUB_HI:`SFE_SUB_LO];

	// Protection of the addressed area; top sector lock covers its subsectors
	assign area_locked = sec_wl_reg[sec_32] | i_hw_prot_sector[sec_32];
	assign sub_locked = area_locked | ((sec_32 == `SFE_TOP_SECTOR) & sub_wl_reg[sub_32]);
	assign sec_locked = area_locked | ((sec_32 == `SFE_TOP_SECTOR) & (|sub_wl_reg));
	assign any_locked = (|i_hw_prot_sector) | (|sec_wl_reg) | (|sub_wl_reg);

	// Command acceptance at select rise, exact length only
	always_comb begin
		do_arm = 1'b0;
		do_disarm = 1'b0;
		do_sleep = 1'b0;
		do_wake = 1'b0;
		do_lock_wr = 1'b0;
		do_page = 1'b0;
		do_sub = 1'b0;
		do_sec = 1'b0;
		do_array = 1'b0;
		if (sel_rise && !hw_rst) begin
			if (state_reg == SFE_ST_SLEEP) begin
				do_wake = (bit_cnt_reg == `SFE_LEN_OP) && (op_8 == `SFE_OP_WAKE);
			end else if (state_reg == SFE_ST_STANDBY && !i_ext_cycle_busy) begin
				if (bit_cnt_reg == `SFE_LEN_OP) begin
					do_arm = (op_8 == `SFE_OP_ARM);
					do_disarm = (op_8 == `SFE_OP_DISARM);
					do_sleep = (op_8 == `SFE_OP_SLEEP);
					do_array = (op_8 == `SFE_OP_ARRAY_CLR) && arm_reg && !any_locked;
				end else if (bit_cnt_reg == `SFE_LEN_ADDR && arm_reg) begin
					do_page = (op_32 == `SFE_OP_PAGE_CLR) && !sub_locked;
					do_sub = (op_32 == `SFE_OP_SUB_CLR) && !sub_locked;
					do_sec = (op_32 == `SFE_OP_SEC_CLR) && !sec_locked;
				end else if (bit_cnt_reg == `SFE_LEN_LOCK && arm_reg) begin
					do_lock_wr = (op_40 == `SFE_OP_LOCK_WR);
				end
			end
		end
	end

	// Cycle state: busy, sleep entry wait, sleep; reset pin aborts all
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			state_reg <= SFE_ST_STANDBY;
			cyc_cnt_reg <= 32'h0000_0000;
		end else if (hw_rst) begin
			state_reg <= SFE_ST_STANDBY;
			cyc_cnt_reg <= 32'h0000_0000;
		end else begin
			case (state_reg)
				SFE_ST_STANDBY: begin
					if (do_page) begin
						state_reg <= SFE_ST_BUSY;
						cyc_cnt_reg <= preload(PAGE_CYC);
					end else if (do_sub) begin
						state_reg <= SFE_ST_BUSY;
						cyc_cnt_reg <= preload(SUB_CYC);
					end else if (do_sec) begin
						state_reg <= SFE_ST_BUSY;
						cyc_cnt_reg <= preload(SEC_CYC);
					end else if (do_array) begin
						state_reg <= SFE_ST_BUSY;
						cyc_cnt_reg <= preload(ARRAY_CYC);
					end else if (do_sleep) begin
						state_reg <= SFE_ST_SLEEP_WAIT;
						cyc_cnt_reg <= preload(`SFE_SLEEP_ENTRY_CYC);
					end
				end
				SFE_ST_BUSY, SFE_ST_SLEEP_WAIT: begin
					// New frames are ignored here, the count runs undisturbed
					if (cyc_cnt_reg == 32'h0000_0000) begin
						state_reg <= (state_reg == SFE_ST_BUSY) ? SFE_ST_STANDBY
							: SFE_ST_SLEEP;
					end else begin
						cyc_cnt_reg <= cyc_cnt_reg - 32'h0000_0001;
					end
				end
				SFE_ST_SLEEP: begin
					if (do_wake) begin
						state_reg <= SFE_ST_STANDBY;
					end
				end
				default: begin
					state_reg <= SFE_ST_STANDBY;
				end
			endcase
		end
	end

	// Erase request to the array, one pulse per accepted erase
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || hw_rst) begin
			o_erase_go <= 1'b0;
			o_erase_kind <= SFE_KIND_PAGE;
			o_erase_addr <= 19'h0_0000;
			o_erase_done <= 1'b0;
		end else begin
			o_erase_go <= do_page | do_sub | do_sec | do_array;
			o_erase_done <= (state_reg == SFE_ST_BUSY) && (cyc_cnt_reg == 32'h0000_0000);
			if (do_page | do_sub | do_sec | do_array) begin
				o_erase_addr <= do_array ? 19'h0_0000 : addr_32;
				o_erase_kind <= do_page ? SFE_KIND_PAGE : do_sub ? SFE_KIND_SUB
					: do_sec ? SFE_KIND_SEC : SFE_KIND_ARRAY;
			end
		end
	end

	// Write-arm latch; cleared as the cycle starts, well before it ends
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || hw_rst) begin
			arm_reg <= 1'b0;
		end else if (do_arm) begin
			arm_reg <= 1'b1;
		end else if (do_disarm || do_lock_wr || o_erase_go) begin
			arm_reg <= 1'b0;
		end
	end

	// Area locks: write lock applied first, freeze second; freeze is sticky
	always_ff @(posedge i_clock) begin
		if (i_sys_rst || hw_rst) begin
			sec_wl_reg <= `SFE_SEC_LOCK_RST;
			sec_ld_reg <= `SFE_SEC_LOCK_RST;
			sub_wl_reg <= `SFE_SUB_LOCK_RST;
			sub_ld_reg <= `SFE_SUB_LOCK_RST;
		end else if (do_lock_wr) begin
			if (lock_data[`SFE_SUB_MODE_BIT] && sec_40 == `SFE_TOP_SECTOR) begin
				// Single subsector of the top sector
				if (!sub_ld_reg[sub_40]) begin
					sub_wl_reg[sub_40] <= lock_data[`SFE_SUB_WL_BIT];
				end
				sub_ld_reg[sub_40] <= sub_ld_reg[sub_40] | lock_data[`SFE_SUB_LD_BIT];
			end else begin
				if (!sec_ld_reg[sec_40]) begin
					sec_wl_reg[sec_40] <= lock_data[`SFE_WL_BIT];
					if (sec_40 == `SFE_TOP_SECTOR && !lock_data[`SFE_WL_BIT]) begin
						sub_wl_reg <= sub_wl_reg & sub_ld_reg;
					end
				end
				sec_ld_reg[sec_40] <= sec_ld_reg[sec_40] | lock_data[`SFE_LD_BIT];
				if (sec_40 == `SFE_TOP_SECTOR && lock_data[`SFE_LD_BIT]) begin
					sub_ld_reg <= 16'hFFFF;
				end
			end
		end
	end

	// Registered status; lags the state by one clock
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_cycle_active_flag <= 1'b0;
			o_write_arm_latch <= 1'b0;
			o_standby <= 1'b1;
			o_deep_sleep <= 1'b0;
		end else begin
			o_cycle_active_flag <= (state_reg == SFE_ST_BUSY);
			o_write_arm_latch <= arm_reg;
			o_standby <= sel_sync_reg && !busy && (state_reg == SFE_ST_STANDBY);
			o_deep_sleep <= (state_reg == SFE_ST_SLEEP);
		end
	end

	// Lock state visible to the program and status logic
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_area_write_lock <= `SFE_SEC_LOCK_RST;
			o_area_freeze_bit <= `SFE_SEC_LOCK_RST;
			o_sub_write_lock <= `SFE_SUB_LOCK_RST;
			o_sub_freeze_bit <= `SFE_SUB_LOCK_RST;
		end else begin
			o_area_write_lock <= sec_wl_reg;
			o_area_freeze_bit <= sec_ld_reg;
			o_sub_write_lock <= sub_wl_reg;
			o_sub_freeze_bit <= sub_ld_reg;
		end
	end
endmodule : sfe_erase_ctrl

// *** hw/sfe_regs.svh ***
// Constants of the erase and power-down sequencer: opcodes, fields, timing
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH

// Opcodes, configurable per product
`define SFE_OP_ARM 8'h06
`define SFE_OP_DISARM 8'h04
`define SFE_OP_PAGE_CLR 8'hDB
`define SFE_OP_SUB_CLR 8'h20
`define SFE_OP_SEC_CLR 8'hD8
`define SFE_OP_ARRAY_CLR 8'hC7
`define SFE_OP_SLEEP 8'hB9
`define SFE_OP_WAKE 8'hAB
`define SFE_OP_LOCK_WR 8'hE5

// Frame lengths in serial bits
`define SFE_LEN_OP 6'd8
`define SFE_LEN_ADDR 6'd32
`define SFE_LEN_LOCK 6'd40
`define SFE_LEN_MAX 6'h3F

// Address fields after A23-A19 are dropped
`define SFE_ADDR_W 19
`define SFE_SEC_HI 18
`define SFE_SEC_LO 16
`define SFE_SUB_HI 15
`define SFE_SUB_LO 12
`define SFE_TOP_SECTOR 3'h7

// Lock byte fields
`define SFE_WL_BIT 0
`define SFE_LD_BIT 1
`define SFE_SUB_WL_BIT 2
`define SFE_SUB_LD_BIT 3
`define SFE_SUB_MODE_BIT 7

// Lock reset values
`define SFE_SEC_LOCK_RST 8'h00
`define SFE_SUB_LOCK_RST 16'h0000

// Timing
`define SFE_CLK_PERIOD_NS 4
`define SFE_SLEEP_ENTRY_NS 3000
`define SFE_SLEEP_ENTRY_CYC ((`SFE_SLEEP_ENTRY_NS + `SFE_CLK_PERIOD_NS - 1) / `SFE_CLK_PERIOD_NS)

`endif

// *** hw/sfe_pkg.sv ***
// Types of the erase and power-down sequencer
package sfe_pkg;
	typedef enum logic [1:0] {
		SFE_KIND_PAGE = 2'b00,
		SFE_KIND_SUB = 2'b01,
		SFE_KIND_SEC = 2'b10,
		SFE_KIND_ARRAY = 2'b11
	} sfe_kind_t;

	typedef enum logic [1:0] {
		SFE_ST_STANDBY = 2'b00,
		SFE_ST_BUSY = 2'b01,
		SFE_ST_SLEEP_WAIT = 2'b10,
		SFE_ST_SLEEP = 2'b11
	} sfe_state_t;
endpackage : sfe_pkg

// *** dv/sfe_erase_ctrl_props.sv ***
// Port checker of the erase and power-down sequencer
`timescale 1ns/1ps
module sfe_erase_ctrl_props (
	input wire logic i_clock, // Clock
	input wire logic i_sys_rst, // Reset
	input wire logic [7:0] i_hw_prot_sector, // Hw protection
	input wire logic o_cycle_active_flag, // Busy
	input wire logic o_write_arm_latch, // Armed
	input wire logic o_deep_sleep, // Asleep
	input wire logic o_erase_go, // Start pulse
	input wire logic [1:0] o_erase_kind, // Region kind
	input wire logic [18:0] o_erase_addr, // Region address
	input wire logic o_erase_done, // End pulse
	input wire logic [7:0] o_area_write_lock, // Sector locks
	input wire logic [15:0] o_sub_write_lock // Subsector locks
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	// Launch needs an armed, idle, awake device
	property p_go_armed;
		o_erase_go |-> o_write_arm_latch;
	endproperty
	a_go_armed: assert property (p_go_armed) else $error("go while unarmed");
	property p_go_idle;
		o_erase_go |-> !o_cycle_active_flag;
	endproperty
	a_go_idle: assert property (p_go_idle) else $error("go while busy");
	property p_sleep_quiet;
		o_deep_sleep |-> !o_cycle_active_flag && !o_erase_go;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("erase in sleep");
	// Busy flag follows the launch and the end of count
	property p_go_start;
		// Latch output trails the busy flag by one clock
		o_erase_go |=> o_cycle_active_flag ##1 !o_write_arm_latch;
	endproperty
	a_go_start: assert property (p_go_start) else $error("cycle not started");
	property p_flag_rise;
		$rose(o_cycle_active_flag) |-> $past(o_erase_go);
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("busy without go");
	property p_done_end;
		o_erase_done |=> !o_cycle_active_flag;
	endproperty
	a_done_end: assert property (p_done_end) else $error("busy after done");
	// Targets in locked or protected sectors never launch; array needs every lock clear
	property p_area_free;
		o_erase_go |-> !o_area_write_lock[o_erase_addr[18:16]]
			&& !i_hw_prot_sector[o_erase_addr[18:16]];
	endproperty
	a_area_free: assert property (p_area_free) else $error("locked go");
	property p_array_free;
		o_erase_go && o_erase_kind == 2'b11 |-> o_area_write_lock == 8'h00
			&& o_sub_write_lock == 16'h0000 && i_hw_prot_sector == 8'h00;
	endproperty
	a_array_free: assert property (p_array_free) else $error("array go locked");
endmodule : sfe_erase_ctrl_props

bind sfe_erase_ctrl sfe_erase_ctrl_props u_props (
	.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hw_prot_sector(i_hw_prot_sector),
	.o_cycle_active_flag(o_cycle_active_flag), .o_write_arm_latch(o_write_arm_latch),
	.o_deep_sleep(o_deep_sleep), .o_erase_go(o_erase_go), .o_erase_kind(o_erase_kind),
	.o_erase_addr(o_erase_addr), .o_erase_done(o_erase_done),
	.o_area_write_lock(o_area_write_lock), .o_sub_write_lock(o_sub_write_lock)
);

// *** dv/sfe_host_model.sv ***
// Host model of the serial link: select, clock and data
`timescale 1ns/1ps
module sfe_host_model (
	input wire logic i_clock, // Pacing clock
	output logic o_sel_n, // Select, low active
	output logic o_sclk, // Serial clock, still outside frames
	output logic o_data // Serial data
);
	initial begin
		o_sel_n = 1'b1;
		o_sclk = 1'b0;
		o_data = 1'b0;
	end
	// One frame of n bits, MSB first from bit 39, ends on a byte boundary
	task automatic send(input logic [39:0] d, input int n);
		@(posedge i_clock);
		o_sel_n <= 1'b0;
		repeat (8) @(posedge i_clock);
		for (int i = 0; i < n; i++) begin
			o_data <= d[39 - i];
			repeat (16) @(posedge i_clock);
			o_sclk <= 1'b1;
			repeat (16) @(posedge i_clock);
			o_sclk <= 1'b0;
		end
		repeat (16) @(posedge i_clock);
		o_sel_n <= 1'b1;
		o_data <= ~o_data; // Released line must not look held
		repeat (10) @(posedge i_clock);
	endtask : send
endmodule : sfe_host_model

// *** dv/tb.sv ***
// Self-checking bench of the erase and power-down sequencer
`timescale 1ns/1ps
`include "sfe_regs.svh"
module tb;
	logic i_clock = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_hw_reset_n = 1'b1;
	logic [7:0] i_hw_prot_sector = 8'h00;
	logic i_ext_cycle_busy = 1'b0;
	logic sel_n, sclk, sdat, cyc, arm, stby, slp, go, done;
	logic [1:0] kind;
	logic [18:0] addr;
	logic [7:0] wl, fz;
	logic [15:0] swl, sfz;
	int err_total = 0;
	int comparisons = 0;
	int gos = 0;
	int dones = 0;
	int ticks = 0;
	always #2 i_clock = ~i_clock;
	sfe_host_model u_sfe_host_model (.i_clock(i_clock), .o_sel_n(sel_n), .o_sclk(sclk),
		.o_data(sdat));
	// Sector count is longer so that commands can land inside it
	sfe_erase_ctrl #(.PAGE_CLEAR_US(1), .SUBSECTOR_CLEAR_US(1), .SECTOR_CLEAR_US(10),
		.ARRAY_CLEAR_US(1)) u_sfe_erase_ctrl (
		.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sel_n(sel_n), .i_sclk(sclk),
		.i_serial_in_line(sdat), .i_hw_reset_n(i_hw_reset_n),
		.i_hw_prot_sector(i_hw_prot_sector), .i_ext_cycle_busy(i_ext_cycle_busy),
		.o_cycle_active_flag(cyc), .o_write_arm_latch(arm), .o_standby(stby),
		.o_deep_sleep(slp), .o_erase_go(go), .o_erase_kind(kind), .o_erase_addr(addr),
		.o_erase_done(done), .o_area_write_lock(wl), .o_area_freeze_bit(fz),
		.o_sub_write_lock(swl), .o_sub_freeze_bit(sfz));
	// Pulse counters and hang guard
	always @(posedge i_clock) begin
		ticks++;
		if (go === 1'b1) gos++;
		if (done === 1'b1) dones++;
		if (ticks == 60000) begin
			err_total++;
			$display("Error at %0t: timeout", $time);
			final_report();
		end
	end
	task automatic chk_b(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_b
	task automatic chk_v(input logic [18:0] got, input logic [18:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk_v
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
		input int n);
		u_sfe_host_model.send({op, a, d}, n);
	endtask : cmd
	task automatic arm_on();
		cmd(`SFE_OP_ARM, 24'h00_0000, 8'h00, 8);
	endtask : arm_on
	// Bounded wait for the end of a cycle, then let standby settle
	task automatic idle();
		for (int i = 0; i < 3000 && cyc === 1'b1; i++) @(posedge i_clock);
		repeat (4) @(posedge i_clock);
	endtask : idle
	task automatic hw_reset();
		@(posedge i_clock);
		i_hw_reset_n <= 1'b0;
		repeat (8) @(posedge i_clock);
		i_hw_reset_n <= 1'b1;
		repeat (16) @(posedge i_clock);
	endtask : hw_reset
	task automatic t_kinds();
		logic [7:0] ops [4] = '{`SFE_OP_PAGE_CLR, `SFE_OP_SUB_CLR, `SFE_OP_SEC_CLR,
			`SFE_OP_ARRAY_CLR};
		int g;
		int d;
		for (int k = 0; k < 4; k++) begin
			g = gos;
			d = dones;
			arm_on();
			chk_b(arm, 1'b1);
			cmd(ops[k], 24'hFD_5678, 8'h00, k == 3 ? 8 : 32);
			chk_v(19'(gos - g), 19'h0_0001);
			chk_v(19'(kind), 19'(k));
			chk_v(addr, k == 3 ? 19'h0_0000 : 19'h5_5678);
			chk_b(cyc, 1'b1);
			chk_b(arm, 1'b0);
			chk_b(stby, 1'b0);
			idle();
			chk_b(cyc, 1'b0);
			chk_v(19'(dones - d), 19'h0_0001);
			chk_b(stby, 1'b1);
		end
		$display("Test kinds finished");
	endtask : t_kinds
	task automatic t_refuse();
		int g;
		g = gos;
		cmd(`SFE_OP_PAGE_CLR, 24'h00_0100, 8'h00, 32);
		arm_on();
		cmd(`SFE_OP_PAGE_CLR, 24'h00_0100, 8'h00, 24);
		cmd(`SFE_OP_ARRAY_CLR, 24'h00_0000, 8'h00, 16);
		chk_v(19'(gos - g), 19'h0_0000);
		cmd(`SFE_OP_DISARM, 24'h00_0000, 8'h00, 8);
		$display("Test refuse finished");
	endtask : t_refuse
	// Commands landing inside a running sector cycle or an outside program cycle
	task automatic t_busy();
		int g;
		arm_on();
		cmd(`SFE_OP_SEC_CLR, 24'h01_0000, 8'h00, 32);
		g = gos;
		arm_on();
		cmd(`SFE_OP_PAGE_CLR, 24'h01_0100, 8'h00, 32);
		cmd(`SFE_OP_SLEEP, 24'h00_0000, 8'h00, 8);
		chk_b(cyc, 1'b1);
		idle();
		repeat (800) @(posedge i_clock);
		chk_b(slp, 1'b0);
		// Arm first, so only the outside cycle can refuse the erase
		arm_on();
		i_ext_cycle_busy <= 1'b1;
		cmd(`SFE_OP_PAGE_CLR, 24'h01_0100, 8'h00, 32);
		i_ext_cycle_busy <= 1'b0;
		chk_v(19'(gos - g), 19'h0_0000);
		$display("Test busy finished");
	endtask : t_busy
	task automatic t_lock();
		logic [7:0] ops [3] = '{`SFE_OP_PAGE_CLR, `SFE_OP_SUB_CLR, `SFE_OP_SEC_CLR};
		int g;
		int d;
		arm_on();
		cmd(`SFE_OP_LOCK_WR, 24'h02_0000, 8'h01, 40);
		chk_v(19'(wl), 19'h0_0004);
		g = gos;
		arm_on();
		cmd(`SFE_OP_SEC_CLR, 24'h02_0000, 8'h00, 32);
		cmd(`SFE_OP_ARRAY_CLR, 24'h00_0000, 8'h00, 8);
		chk_v(19'(gos - g), 19'h0_0000);
		i_hw_prot_sector <= 8'h08;
		for (int k = 0; k < 3; k++) begin
			arm_on();
			cmd(ops[k], 24'h03_1100, 8'h00, 32);
		end
		i_hw_prot_sector <= 8'h00;
		chk_v(19'(gos - g), 19'h0_0000);
		// Top sector: lock it, lock one subsector, then unlock and freeze together
		arm_on();
		cmd(`SFE_OP_LOCK_WR, 24'h07_0000, 8'h01, 40);
		arm_on();
		cmd(`SFE_OP_LOCK_WR, 24'h07_1000, 8'h84, 40);
		chk_v(19'(swl), 19'h0_0002);
		arm_on();
		cmd(`SFE_OP_LOCK_WR, 24'h07_0000, 8'h02, 40);
		chk_v(19'(wl), 19'h0_0004);
		chk_v(19'(fz), 19'h0_0080);
		chk_v(19'(swl), 19'h0_0000);
		chk_v(19'(sfz), 19'h0_FFFF);
		d = dones;
		arm_on();
		cmd(`SFE_OP_SEC_CLR, 24'h00_0000, 8'h00, 32);
		repeat (20) @(posedge i_clock);
		hw_reset();
		chk_b(cyc, 1'b0);
		chk_v(19'(dones - d), 19'h0_0000);
		chk_v({wl, fz[2:0], swl[7:0]}, 19'h0_0000);
		chk_v(19'(fz), 19'h0_0000);
		chk_v(19'(sfz), 19'h0_0000);
		$display("Test lock finished");
	endtask : t_lock
	// Sleep entry delay, refusal while asleep, wake
	task automatic t_sleep();
		int g;
		cmd(`SFE_OP_SLEEP, 24'h00_0000, 8'h00, 8);
		repeat (690) @(posedge i_clock);
		chk_b(slp, 1'b0);
		repeat (100) @(posedge i_clock);
		chk_b(slp, 1'b1);
		g = gos;
		arm_on();
		cmd(`SFE_OP_PAGE_CLR, 24'h00_0100, 8'h00, 32);
		chk_v(19'(gos - g), 19'h0_0000);
		chk_b(arm, 1'b0);
		cmd(`SFE_OP_WAKE, 24'h00_0000, 8'h00, 8);
		chk_b(slp, 1'b0);
		chk_b(stby, 1'b1);
		$display("Test sleep finished");
	endtask : t_sleep
	initial begin
		repeat (6) @(posedge i_clock);
		i_sys_rst <= 1'b0;
		repeat (6) @(posedge i_clock);
		chk_b(stby, 1'b1);
		chk_b(slp, 1'b0);
		t_kinds();
		t_refuse();
		t_busy();
		t_lock();
		t_sleep();
		final_report();
	end
endmodule : tb
